// ==== hdl/bus_pkg.sv ====
// Constants, types and state codes of the multiplexed bus interface
package bus_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int SELECT_COUNT = 8;
  localparam int SELECT_BITS = 10;

  // ----------------------------------------
  // Cycle type codes on the status outputs
  // ----------------------------------------
  localparam logic [2:0] CYC_INTA = 3'h0;
  localparam logic [2:0] CYC_IO_RD = 3'h1;
  localparam logic [2:0] CYC_IO_WR = 3'h2;
  localparam logic [2:0] CYC_HALT = 3'h3;
  localparam logic [2:0] CYC_FETCH = 3'h4;
  localparam logic [2:0] CYC_MEM_RD = 3'h5;
  localparam logic [2:0] CYC_MEM_WR = 3'h6;
  localparam logic [2:0] CYC_IDLE = 3'h7;

  // ----------------------------------------
  // Transfer codes: {address bit 0, byte-high enable}
  // ----------------------------------------
  localparam logic [1:0] XFER_WORD = 2'h0;
  localparam logic [1:0] XFER_EVEN = 2'h1;
  localparam logic [1:0] XFER_ODD = 2'h2;
  localparam logic [1:0] XFER_REFRESH = 2'h3;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [15:0] AD_RESET = 16'h0000;
  localparam logic [3:0] UPPER_RESET = 4'h0;
  localparam logic [7:0] SELECT_RESET = 8'hFF;
  localparam logic CLKOUT_RESET = 1'b0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10,
    ST_HELD = 2'b11
  } bus_state_type;

  typedef struct packed {
    logic [2:0] cyc;
    logic [1:0] xfer;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic lock;
  } bus_req_type;

  typedef struct packed {
    logic enable;
    logic io_space;
    logic ignore_ready;
    logic [SELECT_BITS-1:0] base;
    logic [SELECT_BITS-1:0] mask;
  } select_cfg_type;

endpackage

// ==== hdl/select_match.sv ====
// Address range match for one generic chip select
`timescale 1ns/10ps
module select_match
  import bus_pkg::*;
(
  // Cycle
  input wire logic [19:0] addr,
  input wire logic is_mem,
  input wire logic is_io,
  // Programming
  input wire select_cfg_type cfg,
  // Result
  output logic hit,
  output logic skip_ready
);

  logic space_ok;

  always_comb begin
    space_ok = cfg.io_space ? is_io : is_mem;
    hit = cfg.enable && space_ok &&
          ((addr[19:20-SELECT_BITS] & cfg.mask) == (cfg.base & cfg.mask));
    skip_ready = hit && cfg.ignore_ready;
  end

endmodule

// ==== hdl/muxed_bus_unit.sv ====
// Multiplexed address/data bus interface with chip selects and hold handover
`timescale 1ns/10ps
module muxed_bus_unit
  import bus_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Core request side
  input wire logic req_valid,
  input wire bus_req_type req,
  input wire logic at_boundary,
  output logic done,
  output logic [15:0] rdata,
  // Chip select programming
  input wire select_cfg_type [SELECT_COUNT-1:0] select_cfg,
  // Bus pins
  output logic clkout,
  output logic [3:0] upper_addr,
  input wire logic [15:0] muxed_addr_data_in,
  output logic [15:0] muxed_addr_data_out,
  output logic muxed_addr_data_oe_n,
  output logic ale,
  output logic bhe_n,
  output logic rd_n,
  output logic wr_n,
  output logic den_n,
  output logic xcvr_direction,
  output logic [2:0] cycle_type_n,
  output logic lock_n,
  output logic ctrl_oe_n,
  output logic [SELECT_COUNT-1:0] generic_select_n,
  // Handover and completion pins
  input wire logic hold,
  output logic hlda,
  input wire logic ready
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic hold_m_r, hold_s_r, ready_m_r, ready_s_r;
  logic [15:0] ad_m_r, ad_s_r;
  always_ff @(posedge clock) begin
    hold_m_r <= hold;
    hold_s_r <= hold_m_r;
    ready_m_r <= ready;
    ready_s_r <= ready_m_r;
    ad_m_r <= muxed_addr_data_in;
    ad_s_r <= ad_m_r;
  end
  // ----------------------------------------
  // Bus clock
  // ----------------------------------------
  // Toggles on the falling edge so the rising-edge logic sees a stable phase.
  logic clkout_r, clkout_nxt;
  always_comb begin
    clkout_nxt = rst ? CLKOUT_RESET : !clkout_r;
  end
  always_ff @(negedge clock) begin
    clkout_r <= clkout_nxt;
  end

  // ----------------------------------------
  // Chip select decode
  // ----------------------------------------
  logic [SELECT_COUNT-1:0] hit, skip;
  logic req_mem, req_io;
  always_comb begin
    req_mem = (req.cyc == CYC_FETCH) || (req.cyc == CYC_MEM_RD) || (req.cyc == CYC_MEM_WR);
    req_io = (req.cyc == CYC_IO_RD) || (req.cyc == CYC_IO_WR);
  end
  for (genvar gi = 0; gi < SELECT_COUNT; gi++) begin : g_sel
    select_match u_match (
      .addr(req.addr),
      .is_mem(req_mem),
      .is_io(req_io),
      .cfg(select_cfg[gi]),
      .hit(hit[gi]),
      .skip_ready(skip[gi])
    );
  end
  // ----------------------------------------
  // Bus sequencer
  // ----------------------------------------
  bus_state_type state_r, state_nxt;
  bus_req_type cur_r, cur_nxt;
  logic [3:0] upper_r, upper_nxt;
  logic [15:0] ad_r, ad_nxt, rdata_r, rdata_nxt;
  logic ad_oe_n_r, ad_oe_n_nxt, ale_r, ale_nxt, bhe_n_r, bhe_n_nxt;
  logic rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt, den_n_r, den_n_nxt;
  logic dir_r, dir_nxt, lock_n_r, lock_n_nxt, ctrl_oe_n_r, ctrl_oe_n_nxt;
  logic hlda_r, hlda_nxt, done_r, done_nxt, ign_r, ign_nxt, waited_r, waited_nxt;
  logic [2:0] cyc_n_r, cyc_n_nxt;
  logic [SELECT_COUNT-1:0] sel_n_r, sel_n_nxt;
  logic is_write, has_data;
  always_comb begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    upper_nxt = upper_r;
    ad_nxt = ad_r;
    ad_oe_n_nxt = ad_oe_n_r;
    ale_nxt = ale_r;
    bhe_n_nxt = bhe_n_r;
    rd_n_nxt = rd_n_r;
    wr_n_nxt = wr_n_r;
    den_n_nxt = den_n_r;
    dir_nxt = dir_r;
    lock_n_nxt = lock_n_r;
    ctrl_oe_n_nxt = ctrl_oe_n_r;
    hlda_nxt = hlda_r;
    cyc_n_nxt = cyc_n_r;
    sel_n_nxt = sel_n_r;
    ign_nxt = ign_r;
    rdata_nxt = rdata_r;
    done_nxt = 1'b0;
    waited_nxt = (state_r == ST_DATA) && (waited_r || clkout_r);
    is_write = (cur_r.cyc == CYC_IO_WR) || (cur_r.cyc == CYC_MEM_WR);
    // Refresh and halt cycles move no data, so the transceivers stay shut
    has_data = (cur_r.cyc != CYC_HALT) && (cur_r.xfer != XFER_REFRESH);
    // The data phase lasts two bus clocks at least, so read data has crossed the input flops
    case (state_r)
      ST_IDLE: begin
        if (clkout_r) begin
          if (hold_s_r && at_boundary && lock_n_r) begin
            state_nxt = ST_HELD;
            hlda_nxt = 1'b1;
            ctrl_oe_n_nxt = 1'b1;
            ad_oe_n_nxt = 1'b1;
          end else if (req_valid) begin
            state_nxt = ST_ADDR;
            cur_nxt = req;
            ale_nxt = 1'b1;
            upper_nxt = req.addr[19:16];
            ad_nxt = {req.addr[15:1], req.xfer[1]};
            bhe_n_nxt = req.xfer[0];
            ad_oe_n_nxt = 1'b0;
            cyc_n_nxt = req.cyc;
            lock_n_nxt = !req.lock;
            sel_n_nxt = ~hit;
            ign_nxt = |skip;
            dir_nxt = (req.cyc == CYC_IO_WR) || (req.cyc == CYC_MEM_WR);
          end
        end
      end
      ST_ADDR: begin
        if (clkout_r) begin
          state_nxt = ST_DATA;
          ale_nxt = 1'b0;
          upper_nxt = UPPER_RESET;
          den_n_nxt = !has_data;
          if (is_write) begin
            ad_nxt = cur_r.wdata;
            wr_n_nxt = 1'b0;
          end else begin
            ad_oe_n_nxt = 1'b1;
            rd_n_nxt = (cur_r.cyc == CYC_HALT);
          end
        end
      end
      ST_DATA: begin
        if (clkout_r && waited_r && (ready_s_r || ign_r)) begin
          state_nxt = ST_IDLE;
          rdata_nxt = ad_s_r;
          done_nxt = 1'b1;
          rd_n_nxt = 1'b1;
          wr_n_nxt = 1'b1;
          den_n_nxt = 1'b1;
          ad_oe_n_nxt = 1'b1;
          cyc_n_nxt = CYC_IDLE;
          sel_n_nxt = SELECT_RESET;
          ign_nxt = 1'b0;
        end
      end
      ST_HELD: begin
        if (clkout_r && !hold_s_r) begin
          state_nxt = ST_IDLE;
          hlda_nxt = 1'b0;
          ctrl_oe_n_nxt = 1'b0;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cur_r <= '0;
      upper_r <= UPPER_RESET;
      ad_r <= AD_RESET;
      ad_oe_n_r <= 1'b1;
      ale_r <= 1'b0;
      bhe_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      den_n_r <= 1'b1;
      dir_r <= 1'b1;
      lock_n_r <= 1'b1;
      ctrl_oe_n_r <= 1'b0;
      hlda_r <= 1'b0;
      cyc_n_r <= CYC_IDLE;
      sel_n_r <= SELECT_RESET;
      ign_r <= 1'b0;
      rdata_r <= AD_RESET;
      done_r <= 1'b0;
      waited_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      upper_r <= upper_nxt;
      ad_r <= ad_nxt;
      ad_oe_n_r <= ad_oe_n_nxt;
      ale_r <= ale_nxt;
      bhe_n_r <= bhe_n_nxt;
      rd_n_r <= rd_n_nxt;
      wr_n_r <= wr_n_nxt;
      den_n_r <= den_n_nxt;
      dir_r <= dir_nxt;
      lock_n_r <= lock_n_nxt;
      ctrl_oe_n_r <= ctrl_oe_n_nxt;
      hlda_r <= hlda_nxt;
      cyc_n_r <= cyc_n_nxt;
      sel_n_r <= sel_n_nxt;
      ign_r <= ign_nxt;
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
      waited_r <= waited_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign clkout = clkout_r;
  assign upper_addr = upper_r;
  assign muxed_addr_data_out = ad_r;
  assign muxed_addr_data_oe_n = ad_oe_n_r;
  assign ale = ale_r;
  assign bhe_n = bhe_n_r;
  assign rd_n = rd_n_r;
  assign wr_n = wr_n_r;
  assign den_n = den_n_r;
  assign xcvr_direction = dir_r;
  assign cycle_type_n = cyc_n_r;
  assign lock_n = lock_n_r;
  assign ctrl_oe_n = ctrl_oe_n_r;
  assign generic_select_n = sel_n_r;
  assign hlda = hlda_r;
  assign done = done_r;
  assign rdata = rdata_r;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence addr_phase_s;
    ale_r [*2];
  endsequence
  sequence data_phase_s;
    !ale_r && (state_r == ST_DATA);
  endsequence
  ale_upper_addr_a: assert property (ale_r |-> upper_r == cur_r.addr[19:16])
    else $error("upper address wrong in address phase");
  data_upper_zero_a: assert property ((state_r == ST_DATA) |-> upper_r == 4'h0)
    else $error("upper address not low in data phase");
  addr_on_bus_a: assert property (ale_r |-> !ad_oe_n_r && ad_r[15:1] == cur_r.addr[15:1])
    else $error("address not driven on shared lines");
  ale_sequence_a: assert property ($rose(ale_r) |-> addr_phase_s ##1 data_phase_s)
    else $error("address phase not two clocks followed by data phase");
  xfer_code_a: assert property (ale_r |-> {ad_r[0], bhe_n_r} == cur_r.xfer)
    else $error("transfer code wrong");
  upper_byte_a: assert property (ale_r && !cur_r.xfer[0] |-> !bhe_n_r)
    else $error("byte high enable not low for upper byte");
  clkout_toggle_a: assert property (##1 clkout_r != $past(clkout_r))
    else $error("bus clock did not toggle");
  den_data_a: assert property (!den_n_r |-> state_r == ST_DATA && has_data)
    else $error("data enable outside data transfer");
  direction_a: assert property ((!wr_n_r |-> dir_r) and (!rd_n_r |-> !dir_r))
    else $error("transceiver direction wrong");
  hold_grant_a: assert property ($rose(hlda_r) |-> $past(hold_s_r) && $past(lock_n_r))
    else $error("hold granted without request or under lock");
  held_float_a: assert property (hlda_r |-> ad_oe_n_r && ctrl_oe_n_r)
    else $error("bus not floated while held");
  select_cycle_a: assert property (sel_n_r != SELECT_RESET |-> state_r != ST_IDLE)
    else $error("select active outside a cycle");
  ready_end_a: assert property ((state_r == ST_DATA) ##1 (state_r == ST_IDLE) |->
    $past(ready_s_r) || $past(ign_r))
    else $error("cycle ended without ready");
  idle_status_a: assert property ((state_r == ST_IDLE) && !done_r |-> cyc_n_r == CYC_IDLE)
    else $error("status not idle between cycles");
  read_release_a: assert property (!rd_n_r |-> ad_oe_n_r)
    else $error("shared lines driven during read");
  lock_hold_a: assert property (!lock_n_r |-> ##1 !$rose(hlda_r))
    else $error("hold granted under lock");
  ale_data_low_a: assert property ((state_r == ST_DATA) |-> !ale_r)
    else $error("latch strobe high in data phase");
endmodule

// ==== bench/bus_partner.sv ====
// Memory and peripheral model on the far side of the multiplexed bus
`timescale 1ns/10ps
module bus_partner (
  // Clock
  input wire logic clock,
  // Bus pins
  input wire logic ale,
  input wire logic [3:0] upper_addr,
  input wire logic [15:0] addr_data,
  input wire logic rd_n,
  // Pacing
  input wire logic stall,
  input wire logic [1:0] wait_states,
  // Answers
  output logic ready,
  output logic [15:0] drive_data
);
  logic [19:0] addr_r = 20'h00000;
  logic [15:0] last_r = 16'h0000;
  logic [2:0] count_r = 3'h0;

  always_ff @(posedge clock) begin
    if (ale)
      addr_r <= {upper_addr, addr_data};
    if (ale)
      count_r <= 3'h0;
    else if (count_r != 3'h7)
      count_r <= count_r + 3'h1;
    if (!rd_n)
      last_r <= drive_data;
  end

  // Released lines show the inverse of the last value so no stale data passes
  assign drive_data = !rd_n ? (addr_r[15:0] ^ 16'h5A3C) : ~last_r;
  assign ready = !stall && (count_r >= {1'b0, wait_states});
endmodule

// ==== bench/test_multiplexed_bus_interface.sv ====
// Self-checking bench of the multiplexed bus interface
`timescale 1ns/10ps
module test_multiplexed_bus_interface import bus_pkg::*;;
  localparam logic [9:0] REGION = 10'h2B5;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  bus_req_type req = '0;
  logic at_boundary = 1'b0;
  logic hold = 1'b0;
  logic stall = 1'b0;
  logic [1:0] wait_states = 2'h0;
  select_cfg_type [SELECT_COUNT-1:0] select_cfg;
  logic [15:0] rdata, ad_in, ad_out, slave_data;
  logic [3:0] upper_addr;
  logic [2:0] cycle_type_n;
  logic [7:0] generic_select_n;
  logic done, clkout, ale, bhe_n, rd_n, wr_n, den_n, ad_oe_n, xcvr_direction;
  logic lock_n, ctrl_oe_n, hlda, ready, clk_prev, clk_seen, ale_prev;
  int num_errors = 0;
  int comparisons = 0;
  int seed = 46903;
  int done_count = 0;
  bus_req_type notes[$];

  assign ad_in = ad_oe_n ? slave_data : ad_out;

  muxed_bus_unit uut (.clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
    .at_boundary(at_boundary), .done(done), .rdata(rdata), .select_cfg(select_cfg),
    .clkout(clkout), .upper_addr(upper_addr), .muxed_addr_data_in(ad_in),
    .muxed_addr_data_out(ad_out), .muxed_addr_data_oe_n(ad_oe_n), .ale(ale), .bhe_n(bhe_n),
    .rd_n(rd_n), .wr_n(wr_n), .den_n(den_n), .xcvr_direction(xcvr_direction),
    .cycle_type_n(cycle_type_n), .lock_n(lock_n), .ctrl_oe_n(ctrl_oe_n),
    .generic_select_n(generic_select_n), .hold(hold), .hlda(hlda), .ready(ready));

  bus_partner partner (.clock(clock), .ale(ale), .upper_addr(upper_addr), .addr_data(ad_in),
    .rd_n(rd_n), .stall(stall), .wait_states(wait_states), .ready(ready),
    .drive_data(slave_data));

  initial begin
    forever #2 clock = ~clock;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wait_level(ref logic sig, input logic val, input int bound);
    int n;
    n = 0;
    while (sig !== val && n < bound) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (sig !== val) begin
      num_errors++;
      $display("Error at %0t: wait ran out", $time);
      print_verdict();
    end
  endtask

  task automatic do_cycle(input bus_req_type r);
    notes.push_back(r);
    req <= r;
    req_valid <= 1'b1;
    @(posedge clock);
    #1;
    wait_level(done, 1'b1, 300);
    req_valid <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  function automatic bus_req_type make_req(input logic [2:0] cyc, input logic [1:0] xfer,
      input logic lock);
    bus_req_type r;
    r.cyc = cyc;
    r.xfer = xfer;
    r.lock = lock;
    r.addr = {REGION, 10'($random(seed))};
    r.wdata = 16'($random(seed));
    return r;
  endfunction

  // Odd selects watch I/O space, even ones memory; the last stays disabled
  function automatic logic [7:0] exp_sel(input logic [2:0] cyc);
    logic io;
    logic mem;
    io = (cyc == CYC_IO_RD) || (cyc == CYC_IO_WR);
    mem = (cyc == CYC_FETCH) || (cyc == CYC_MEM_RD) || (cyc == CYC_MEM_WR);
    for (int i = 0; i < 8; i++)
      exp_sel[i] = !((i != 7) && (i[0] ? io : mem));
  endfunction

  // ----------------------------------------
  // Output monitor
  // ----------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      clk_seen <= 1'b0;
    end else begin
      if (clk_seen)
        check(clkout === ~clk_prev, "bus clock");
      if (ale && !ale_prev && notes.size() > 0) begin
        check(upper_addr === notes[0].addr[19:16], "upper address");
        check(ad_out === {notes[0].addr[15:1], notes[0].xfer[1]} && !ad_oe_n, "address");
        check(bhe_n === notes[0].xfer[0], "byte high");
        check(cycle_type_n === notes[0].cyc, "status");
        check(generic_select_n === exp_sel(notes[0].cyc), "selects");
      end
      if (!rd_n || !wr_n)
        check(upper_addr === 4'h0 && ale === 1'b0, "data phase");
      if (!wr_n && notes.size() > 0)
        check(ad_out === notes[0].wdata && !ad_oe_n && xcvr_direction === 1'b1
          && den_n === (notes[0].xfer == XFER_REFRESH), "write");
      if (!rd_n && notes.size() > 0)
        check(ad_oe_n && xcvr_direction === 1'b0
          && den_n === (notes[0].xfer == XFER_REFRESH), "read");
      if (rd_n && wr_n)
        check(den_n === 1'b1, "data enable idle");
      if (done && notes.size() > 0) begin
        done_count <= done_count + 1;
        if (notes[0].cyc inside {CYC_IO_RD, CYC_MEM_RD, CYC_FETCH})
          check(rdata === ({notes[0].addr[15:1], notes[0].xfer[1]} ^ 16'h5A3C), "rdata");
        void'(notes.pop_front());
      end
      clk_prev <= clkout;
      clk_seen <= 1'b1;
    end
    ale_prev <= ale;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int start;
    for (int i = 0; i < SELECT_COUNT; i++)
      select_cfg[i] = '{enable: (i != 7), io_space: i[0], ignore_ready: (i == 3),
        base: REGION, mask: 10'h3FF};
    repeat (8) @(posedge clock);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 7; i++)
      do_cycle(make_req(3'(i), 2'(i), 1'b0));
    for (int i = 0; i < 24; i++) begin
      wait_states = 2'($random(seed));
      do_cycle(make_req(3'(1 + $unsigned($random(seed)) % 6), 2'($random(seed)), 1'b0));
    end
    start = done_count;
    stall = 1'b1;
    fork
      do_cycle(make_req(CYC_MEM_RD, XFER_WORD, 1'b0));
      begin
        repeat (40) @(posedge clock);
        #1;
        check(done_count == start, "ended without ready");
        stall = 1'b0;
      end
    join
    stall = 1'b1;
    do_cycle(make_req(CYC_IO_RD, XFER_WORD, 1'b0));
    stall = 1'b0;
    hold = 1'b1;
    repeat (20) @(posedge clock);
    #1;
    check(hlda === 1'b0, "hold off boundary");
    at_boundary = 1'b1;
    wait_level(hlda, 1'b1, 20);
    check(ad_oe_n === 1'b1 && ctrl_oe_n === 1'b1, "bus floated");
    hold = 1'b0;
    wait_level(hlda, 1'b0, 20);
    check(ctrl_oe_n === 1'b0, "bus taken back");
    do_cycle(make_req(CYC_MEM_WR, XFER_EVEN, 1'b1));
    check(lock_n === 1'b0, "lock");
    hold = 1'b1;
    repeat (20) @(posedge clock);
    #1;
    check(hlda === 1'b0, "hold while locked");
    do_cycle(make_req(CYC_MEM_RD, XFER_ODD, 1'b0));
    wait_level(hlda, 1'b1, 20);
    hold = 1'b0;
    wait_level(hlda, 1'b0, 20);
    repeat (4) @(posedge clock);
    print_verdict();
  end
endmodule
